// ==== logic/fes_cycle.sv ====
// pin-level driver: performs one write or read cycle on the flash bus
`timescale 1ns/1ps
`include "fes_cfg.svh"
module fes_cycle #(
	parameter int ADDR_W = 21
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// cycle requests
	fes_bus_if.pins bus,
	// flash pins
	output logic [ADDR_W-1:0] fl_addr,
	output logic [7:0] fl_dq_out,
	output logic fl_dq_oe_n,
	input wire logic [7:0] fl_dq_in,
	output logic fl_ce_n,
	output logic fl_we_n,
	output logic fl_oe_n
);
	localparam logic [7:0] WE_CYC = 8'(`FES_WE_CYC);
	localparam logic [7:0] RD_CYC = 8'(`FES_RD_CYC);
	logic [7:0] cnt;
	logic busy;
	logic rd;
	wire last = busy && (cnt == 8'h00);

	// strobe counts cover the device access time; data is captured on the final cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			rd <= 1'b0;
			cnt <= 8'h00;
			bus.done <= 1'b0;
			bus.rdata <= 8'h00;
			fl_addr <= '0;
			fl_dq_out <= 8'h00;
			fl_dq_oe_n <= 1'b1;
			fl_ce_n <= 1'b1;
			fl_we_n <= 1'b1;
			fl_oe_n <= 1'b1;
		end else if (ce) begin
			bus.done <= last;
			if (bus.req && !busy) begin
				busy <= 1'b1;
				rd <= !bus.wr;
				cnt <= bus.wr ? WE_CYC : RD_CYC;
				fl_addr <= bus.addr[ADDR_W-1:0];
				fl_dq_out <= bus.wdata;
				fl_dq_oe_n <= !bus.wr; // drive only on writes
				fl_ce_n <= 1'b0;
				fl_we_n <= !bus.wr;
				fl_oe_n <= bus.wr;
			end else if (last) begin
				busy <= 1'b0;
				if (rd)
					bus.rdata <= fl_dq_in;
				fl_ce_n <= 1'b1;
				fl_we_n <= 1'b1;
				fl_oe_n <= 1'b1;
				fl_dq_oe_n <= 1'b1;
			end else if (busy) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule

// ==== logic/fes_host.sv ====
// host controller that sequences erase and byte write commands and checks status
`timescale 1ns/1ps
`include "fes_cfg.svh"
module fes_host #(
	parameter int ADDR_W = 21
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// user orders
	input wire logic op_start,
	input wire fes_pkg::fes_op_t op_kind,
	input wire logic [ADDR_W-1:0] op_addr,
	input wire logic [7:0] op_data,
	input wire logic op_check,
	output logic op_busy,
	output logic op_done,
	output fes_pkg::fes_res_t op_result,
	output logic [7:0] op_status,
	// flash pins
	output logic [ADDR_W-1:0] fl_addr,
	output logic [7:0] fl_dq_out,
	output logic fl_dq_oe_n,
	input wire logic [7:0] fl_dq_in,
	output logic fl_ce_n,
	output logic fl_we_n,
	output logic fl_oe_n,
	input wire logic ready_busy_output
);
	import fes_pkg::*;

	typedef enum logic [2:0] {
		st_idle, st_cmd1, st_cmd2, st_poll, st_check, st_clear, st_finish
	} fes_state_t;

	// operation latched at acceptance; the user inputs may change during the run
	fes_state_t state;
	fes_bus_if bus();
	logic [ADDR_W-1:0] addr;
	logic [7:0] data;
	fes_op_t kind;
	logic check;
	logic [2:0] rb_sync;
	logic pending;

	// rb_sync[0] is only read by rb_sync[1]
	wire rb_ready = rb_sync[1] & rb_sync[2];
	wire [7:0] sr = bus.rdata & `FES_SR_POLL_MASK;
	wire sr_ready = sr[`FES_SR_READY];
	wire sr_ee = sr[`FES_SR_ERASE_ERR];
	wire sr_pe = sr[`FES_SR_PROG_ERR];
	wire sr_vl = sr[`FES_SR_SUPPLY_LOW];
	wire sr_dp = sr[`FES_SR_PROTECT];
	// erase and byte write take two cycles and then a poll
	wire two_cycle = (kind == fes_op_erase) || (kind == fes_op_write);

	// full check order: supply, protect, sequence, then the operation's own failure
	function automatic fes_res_t grade(input logic [7:0] s, input fes_op_t k);
		if (s[`FES_SR_SUPPLY_LOW])
			return fes_res_supply;
		else if (s[`FES_SR_PROTECT])
			return fes_res_protect;
		else if (s[`FES_SR_ERASE_ERR] && s[`FES_SR_PROG_ERR])
			return fes_res_sequence;
		else if (s[`FES_SR_ERASE_ERR] && k == fes_op_erase)
			return fes_res_erase_fail;
		else if (s[`FES_SR_PROG_ERR])
			return fes_res_write_fail;
		else
			return fes_res_ok;
	endfunction

	wire fes_res_t graded = grade(sr, kind);
	// first command byte of each operation
	wire [7:0] first_code = (kind == fes_op_erase) ? `FES_CMD_ERASE_SETUP :
		(kind == fes_op_write) ? `FES_CMD_WRITE_SETUP :
		(kind == fes_op_clear) ? `FES_CMD_CLEAR_STATUS : `FES_CMD_READ_ARRAY;
	wire [7:0] second_code = (kind == fes_op_erase) ? `FES_CMD_ERASE_CONFIRM : data;

	// what the current state writes: clear after an error, then array mode to finish
	wire [7:0] req_code = (state == st_cmd2) ? second_code :
		(state == st_clear) ? `FES_CMD_CLEAR_STATUS :
		(state == st_finish) ? `FES_CMD_READ_ARRAY : first_code;
	// one cycle in flight at a time; grading needs no bus cycle at all
	wire req_due = !pending && state != st_idle && state != st_check;
	// status polls are the only reads, since every read after a sequence returns status
	wire req_wr = state != st_poll;

	fes_cycle #(.ADDR_W(ADDR_W)) u_cycle (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.bus(bus.pins),
		.fl_addr(fl_addr),
		.fl_dq_out(fl_dq_out),
		.fl_dq_oe_n(fl_dq_oe_n),
		.fl_dq_in(fl_dq_in),
		.fl_ce_n(fl_ce_n),
		.fl_we_n(fl_we_n),
		.fl_oe_n(fl_oe_n)
	);

	// three-stage sampler for the asynchronous ready/busy pin
	// a glitch shorter than a clock cannot pass, since two stages must agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rb_sync <= 3'h7;
		else if (ce)
			rb_sync <= {rb_sync[1:0], ready_busy_output};
	end

	// bus request path: one request at a time, a new poll read after each answer; pending holds until the driver answers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.req <= 1'b0;
			bus.wr <= 1'b0;
			bus.addr <= '0;
			bus.wdata <= 8'h00;
			pending <= 1'b0;
		end else if (ce) begin
			bus.req <= 1'b0;
			if (bus.done)
				pending <= 1'b0;
			else if (req_due) begin
				pending <= 1'b1;
				bus.req <= 1'b1;
				bus.addr <= addr; // same block, same location
				bus.wr <= req_wr;
				bus.wdata <= req_code;
			end
		end
	end

	// sequencing: setup, confirm, poll, grade, recover, return to array
	// limitation: there is no give-up count, so a device that never turns ready keeps
	// op_busy high; the user side must bound its own wait
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= st_idle;
			addr <= '0;
			data <= 8'h00;
			kind <= fes_op_read_array;
			check <= 1'b0;
			op_busy <= 1'b0;
			op_done <= 1'b0;
			op_result <= fes_res_ok;
			op_status <= 8'h00;
		end else if (ce) begin
			op_done <= 1'b0;
			case (state)
				st_idle: begin
					if (op_start) begin
						addr <= op_addr;
						data <= op_data;
						kind <= op_kind;
						check <= op_check;
						op_busy <= 1'b1;
						state <= st_cmd1;
					end
				end
				st_cmd1: begin
					// clear status and array mode are single writes and end here
					if (bus.done)
						state <= two_cycle ? st_cmd2 : st_idle;
					if (bus.done && !two_cycle) begin
						op_busy <= 1'b0;
						op_done <= 1'b1;
						op_result <= fes_res_ok;
					end
				end
				st_cmd2: begin
					// from here on every read returns status
					if (bus.done)
						state <= st_poll;
				end
				st_poll: begin
					// other bits are untrusted until ready; the pin must agree too
					if (bus.done && sr_ready && rb_ready)
						state <= st_check;
				end
				st_check: begin
					// the last status stays visible to the user after done
					op_status <= sr;
					// every erase and byte write is graded and any error cleared here, so op_check changes no result
					if (check || graded != fes_res_ok) begin
						op_result <= graded;
						state <= (graded != fes_res_ok) ? st_clear : st_finish;
					end else begin
						op_result <= fes_res_ok;
						state <= st_finish;
					end
				end
				st_clear: begin
					if (bus.done)
						state <= st_finish;
				end
				st_finish: begin
					// array mode comes back on the clean path and after a clear alike
					if (bus.done) begin
						op_busy <= 1'b0;
						op_done <= 1'b1;
						state <= st_idle;
					end
				end
				default: state <= st_idle;
			endcase
		end
	end
endmodule

// ==== shared/fes_bus_if.sv ====
// one bus cycle request and its answer between sequencer and pin driver
`timescale 1ns/1ps
interface fes_bus_if;
	logic req;
	logic wr;
	logic [20:0] addr;
	logic [7:0] wdata;
	logic done;
	logic [7:0] rdata;
	modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
	modport pins (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ==== shared/fes_cfg.svh ====
// timing counts, command codes and status bit positions for the flash sequencer host
`ifndef FES_CFG_SVH
`define FES_CFG_SVH
`define FES_CMD_ERASE_SETUP 8'h20
`define FES_CMD_ERASE_CONFIRM 8'hD0
`define FES_CMD_WRITE_SETUP 8'h40
`define FES_CMD_READ_ARRAY 8'hFF
`define FES_CMD_CLEAR_STATUS 8'h50
`define FES_CMD_READ_STATUS 8'h70
`define FES_SR_READY 7
`define FES_SR_ERASE_PAUSED 6
`define FES_SR_ERASE_ERR 5
`define FES_SR_PROG_ERR 4
`define FES_SR_SUPPLY_LOW 3
`define FES_SR_PROG_PAUSED 2
`define FES_SR_PROTECT 1
`define FES_SR_RESERVED 0
`define FES_SR_POLL_MASK 8'hFE
`define FES_CLK_MHZ 125
`define FES_T_WE_NS 64
`define FES_T_RD_NS 120
`define FES_WE_CYC ((`FES_T_WE_NS * `FES_CLK_MHZ + 999) / 1000)
`define FES_RD_CYC ((`FES_T_RD_NS * `FES_CLK_MHZ + 999) / 1000)
`endif

// ==== shared/fes_pkg.sv ====
// types shared by the flash sequencer host modules
package fes_pkg;
	typedef enum logic [1:0] {
		fes_op_erase,
		fes_op_write,
		fes_op_clear,
		fes_op_read_array
	} fes_op_t;
	typedef enum logic [2:0] {
		fes_res_ok,
		fes_res_supply,
		fes_res_protect,
		fes_res_sequence,
		fes_res_erase_fail,
		fes_res_write_fail
	} fes_res_t;
endpackage

// ==== tb/fes_flash_model.sv ====
// behavioural flash device: command decode, status byte, ready/busy pin
`timescale 1ns/1ps
module fes_flash_model #(
	parameter logic [7:0] ID_CMD = 8'h90 // identifier-read code, value arbitrary here
) (
	// flash pins
	input wire logic [20:0] fl_addr,
	input wire logic [7:0] fl_dq_out,
	input wire logic fl_ce_n,
	input wire logic fl_dq_oe_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n,
	output logic [7:0] fl_dq_in,
	output logic ready_busy_output = 1'b1,
	// bench controls: 1 supply low, 2 locked, 3 bad sequence, 4 fail
	input wire logic [2:0] fault,
	input wire logic [11:0] busy_ns
);
	logic [7:0] sr = 8'h80;
	logic [7:0] pend = 8'h00;
	logic [7:0] e;
	logic [20:0] paddr;
	logic show_sr = 1'b0;
	logic show_id = 1'b0;
	// a write counts only with chip enabled and data driven; a released bus reads inverted
	wire wr_strobe = !fl_we_n && !fl_ce_n && !fl_dq_oe_n;
	// lock state shows in identifier mode, and through the protect bit once an erase or write completes
	wire [7:0] idq = {7'h00, fault == 3'h2};
	// junk while busy and a set reserved bit expose a careless poll
	wire [7:0] q = show_id ? idq :
		show_sr ? (sr[7] ? sr | 8'h01 : 8'h7F) : fl_addr[7:0];
	assign fl_dq_in = (fl_oe_n || fl_ce_n) ? ~q : q;
	// commands are taken as the write strobe ends
	always @(negedge wr_strobe) begin
		if (pend != 8'h00) begin
			e = pend == 8'h20 ? 8'h20 : 8'h10;
			if (fl_addr != paddr || (pend == 8'h20 && fl_dq_out != 8'hD0) || fault == 3)
				sr = sr | 8'h30;
			else begin
				sr[7] = 1'b0;
				ready_busy_output = 1'b0;
				#(busy_ns);
				if (fault == 1)
					sr = sr | 8'h08 | e;
				else if (fault == 2)
					sr = sr | 8'h02 | e;
				else if (fault == 4)
					sr = sr | e;
				sr[7] = 1'b1;
				ready_busy_output = 1'b1;
			end
			pend = 8'h00;
		end else begin
			show_id = 1'b0;
			case (fl_dq_out)
				8'h20, 8'h40: begin
					pend = fl_dq_out;
					paddr = fl_addr;
					show_sr = 1'b1;
				end
				8'h50: sr[5:1] = 5'h00;
				8'h70: show_sr = 1'b1;
				ID_CMD: show_id = 1'b1;
				8'hFF: show_sr = 1'b0;
				default: ;
			endcase
		end
	end
endmodule

// ==== tb/fes_host_properties.sv ====
// port-level checks for the flash sequencer host
`timescale 1ns/1ps
module fes_host_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// user side
	input wire logic op_start,
	input wire logic op_busy,
	input wire logic op_done,
	input wire fes_pkg::fes_op_t op_kind,
	input wire logic [7:0] op_data,
	input wire fes_pkg::fes_res_t op_result,
	input wire logic [7:0] op_status,
	// flash side
	input wire logic [7:0] fl_dq_out,
	input wire logic fl_we_n,
	input wire logic ready_busy_output
);
	import fes_pkg::*;
	logic saw_clear;
	logic [7:0] last_wr;
	wire rw_op = op_kind == fes_op_erase || op_kind == fes_op_write;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// last command byte and whether this op cleared status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			saw_clear <= 1'b0;
			last_wr <= 8'h00;
		end else begin
			if (!fl_we_n)
				last_wr <= fl_dq_out;
			if (op_start && !op_busy)
				saw_clear <= 1'b0;
			else if (!fl_we_n && fl_dq_out == 8'h50)
				saw_clear <= 1'b1;
		end
	end
	property p_mask; op_done |-> !op_status[0]; endproperty
	a_mask: assert property (p_mask) else $error("reserved bit reported");
	property p_ready; op_done && rw_op |-> $past(ready_busy_output, 2) && op_status[7]; endproperty
	a_ready: assert property (p_ready) else $error("done before ready");
	property p_erase;
		op_kind == fes_op_erase && $fell(fl_we_n) && fl_dq_out == 8'h20
		|-> ##[2:60] ($fell(fl_we_n) && fl_dq_out == 8'hD0);
	endproperty
	a_erase: assert property (p_erase) else $error("erase confirm missing");
	property p_write;
		op_kind == fes_op_write && $fell(fl_we_n) && fl_dq_out == 8'h40
		|-> ##[2:60] ($fell(fl_we_n) && fl_dq_out == op_data);
	endproperty
	a_write: assert property (p_write) else $error("data cycle missing");
	property p_ffh; op_done && op_kind != fes_op_clear |-> last_wr == 8'hFF; endproperty
	a_ffh: assert property (p_ffh) else $error("array mode not restored");
	property p_clear; op_done && op_result != fes_res_ok |-> saw_clear; endproperty
	a_clear: assert property (p_clear) else $error("error left uncleared");
	property p_supply; op_done && rw_op && op_status[3] |-> op_result == fes_res_supply; endproperty
	a_supply: assert property (p_supply) else $error("supply not graded first");
	property p_seq;
		op_done && rw_op && op_status[5:3] == 3'b110 && !op_status[1]
		|-> op_result == fes_res_sequence;
	endproperty
	a_seq: assert property (p_seq) else $error("sequence error misgraded");
endmodule

// ==== tb/test_fes_host.sv ====
// self-checking bench: host controller against the flash device model
`timescale 1ns/1ps
module test_fes_host;
	import fes_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic op_start = 1'b0;
	fes_op_t op_kind = fes_op_erase;
	logic [20:0] op_addr = 21'h00_0000;
	logic [7:0] op_data = 8'h00;
	logic op_check = 1'b0;
	logic op_busy, op_done, fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, ready_busy_output;
	fes_res_t op_result;
	logic [7:0] op_status, fl_dq_out, fl_dq_in;
	logic [20:0] fl_addr;
	logic [2:0] fault = 3'h0;
	logic [11:0] busy_ns = 12'h064;
	logic [11:0] exp_q[$];
	logic [11:0] e;
	logic [11:0] got;
	int miscompares = 0;
	int tests_run = 0;
	always #4 clk = ~clk;
	fes_host u_dut (.*);
	fes_flash_model u_dev (.*);
	task automatic test_done;
		$display("compared %0d, mismatched %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// status is only compared where the op actually polled it
	always @(posedge clk) begin
		// done stands while the clock enable is low, so it is taken on an enabled edge
		if (op_done === 1'b1 && ce) begin
			e = exp_q.pop_front();
			got = {op_busy, op_result, e[11] ? op_status : e[7:0]};
			tests_run++;
			if (got !== {1'b0, e[10:0]}) begin
				miscompares++;
				$display("MISMATCH at %0t exp %h got %h", $time, {1'b0, e[10:0]}, got);
			end
		end
	end
	// one operation with random address, data, check and device delay
	task automatic run(input fes_op_t k, input logic [2:0] f, input logic [11:0] x);
		int i;
		fault = f;
		busy_ns = 12'(40 + $urandom % 2000);
		exp_q.push_back(x);
		@(posedge clk);
		op_kind <= k;
		op_addr <= 21'($urandom);
		op_data <= 8'($urandom % 64);
		op_check <= 1'($urandom);
		op_start <= 1'b1;
		@(posedge clk);
		op_start <= 1'b0;
		// brief clock-enable pauses show that every stage freezes and resumes
		for (i = 0; i < 9000 && op_done !== 1'b1; i++) begin
			ce <= (i % 7 != 3);
			@(posedge clk);
		end
		ce <= 1'b1;
		if (i == 9000) begin
			miscompares++;
			test_done;
		end
		$display("test %0d ends", tests_run);
		repeat (2) @(posedge clk);
	endtask
	initial begin
		void'($urandom(76600));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		run(fes_op_write, 0, {1'b1, fes_res_ok, 8'h80});
		run(fes_op_erase, 0, {1'b1, fes_res_ok, 8'h80});
		run(fes_op_write, 1, {1'b1, fes_res_supply, 8'h98});
		run(fes_op_erase, 2, {1'b1, fes_res_protect, 8'hA2});
		run(fes_op_erase, 3, {1'b1, fes_res_sequence, 8'hB0});
		run(fes_op_erase, 4, {1'b1, fes_res_erase_fail, 8'hA0});
		run(fes_op_write, 4, {1'b1, fes_res_write_fail, 8'h90});
		run(fes_op_write, 0, {1'b1, fes_res_ok, 8'h80});
		run(fes_op_clear, 0, {1'b0, fes_res_ok, 8'h00});
		run(fes_op_read_array, 0, {1'b0, fes_res_ok, 8'h00});
		test_done;
	end
endmodule
bind fes_host fes_host_props u_props (.*);
